//--- rtl/bsfeu_pkg.sv
// package: register map, field layout, opcodes and flag positions
package bsfeu_pkg;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CMD     = 8'h00;
  localparam logic [7:0] ADDR_OPERAND = 8'h04;
  localparam logic [7:0] ADDR_FLAGS   = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_IO_BASE = 8'h20;
  localparam int         IO_COUNT     = 8;
  localparam int         IO_AW        = 3;

  // ****************************************************************
  // command register fields
  // ****************************************************************
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_BIT_LSB = 4;
  localparam int CMD_IO_LSB  = 8;

  // ****************************************************************
  // flag_register bit positions
  // ****************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ****************************************************************
  // status register bits and reset values
  // ****************************************************************
  localparam int         STAT_BUSY   = 0;
  localparam int         STAT_BREAK  = 1;
  localparam int         STAT_SLEEP  = 2;
  localparam logic [7:0] FLAGS_RST   = 8'h00;
  localparam logic [7:0] OPERAND_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    OP_NOP, OP_SET_IO_BIT, OP_CLEAR_IO_BIT, OP_SHIFT_LEFT_LOGICAL,
    OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
    OP_SHIFT_RIGHT_ARITHMETIC, OP_NIBBLE_SWAP,
    OP_STORE_REG_BIT_TO_TRANSFER_FLAG, OP_LOAD_TRANSFER_FLAG_TO_REG_BIT,
    OP_FLAG_SET, OP_FLAG_CLEAR, OP_SLEEP, OP_WATCHDOG_RESTART_OP,
    OP_DEBUG_BREAK
  } bsfeu_op_t;

  typedef enum logic [1:0] {
    SEL_CMD, SEL_OPERAND, SEL_FLAGS, SEL_STATUS
  } bsfeu_sel_t;

  typedef enum {ST_IDLE, ST_EXEC, ST_IO_WR} bsfeu_state_t;

endpackage

//--- rtl/bsfeu_top.sv
// execution unit for bit, shift, flag and mcu-control instructions
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps

// Function
// RULE1: set_io_bit forces addressed io bit to one, no flags, two cycles.
// RULE2: clear_io_bit forces addressed io bit to zero, no flags, two cycles.
// RULE3: shift left logical, zero into bit 0, updates Z C N V, one cycle.
// RULE4: shift right logical, zero into bit 7, updates Z C N V, one cycle.
// RULE5: rotate left through carry, old bit 7 into carry, one cycle.
// RULE6: rotate right through carry, old bit 0 into carry, one cycle.
// RULE7: arithmetic shift right keeps bit 7, updates Z C N V, one cycle.
// RULE8: nibble swap exchanges halves, no flags changed, one cycle.
// RULE9: copy selected operand bit into transfer flag only, one cycle.
// RULE10: write transfer flag into selected operand bit, no flags, one cycle.
// RULE11: set or clear overflow flag only.
// RULE12: set or clear signed test flag only, one cycle.
// RULE13: set or clear half carry flag only, one cycle.
// RULE14: sleep takes one cycle, no flags; sleep logic lives elsewhere.
// RULE15: watchdog restart takes one cycle, no flags, signals watchdog.
// RULE16: debug break only signals debug facility, no flags changed.
// RULE17: set or clear carry, zero, negative, transfer flag only, one cycle.
// RULE18: enable or disable global interrupt flag only, one cycle.
module bsfeu_top
  import bsfeu_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             WDT_RESTART,
  output logic             SLEEP_REQ,
  output logic             DEBUG_BREAK,
  output logic             BUSY
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  function automatic logic is_io(input logic [7:0] addr);
    is_io = (addr[7:5] == ADDR_IO_BASE[7:5]) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic is_ctl(input logic [7:0] addr);
    is_ctl = (addr[7:4] == 4'h0) && (addr[1:0] == 2'h0);
  endfunction

  function automatic bsfeu_sel_t reg_sel(input logic [7:0] addr);
    reg_sel = bsfeu_sel_t'(addr[3:2]);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  bsfeu_state_t state_reg;
  logic [7:0]   operand_reg;
  logic [7:0]   operand_next;
  logic [7:0]   flags_reg;
  logic [7:0]   flags_next;
  logic [3:0]   cmd_op_reg;
  logic [2:0]   cmd_bit_reg;
  logic [2:0]   cmd_io_reg;
  logic [7:0]   io_tmp_reg;
  logic [7:0]   io_mem_reg [IO_COUNT];
  logic         break_seen_reg;
  logic         sleep_seen_reg;
  logic         busy_reg;

  logic [7:0]   aw_addr_reg;
  logic [31:0]  w_data_reg;
  logic [3:0]   w_strb_reg;
  logic         aw_got_reg;
  logic         w_got_reg;
  logic         awready_reg;
  logic         wready_reg;
  logic         bvalid_reg;
  logic [1:0]   bresp_reg;
  logic         arready_reg;
  logic         rvalid_reg;
  logic [31:0]  rdata_reg;
  logic [1:0]   rresp_reg;
  logic         wdt_reg;
  logic         sleep_reg;
  logic         break_reg;

  bsfeu_op_t    op;
  logic         exec;
  logic         wr_fire;
  logic [31:0]  wr_data;
  logic         wr_cmd;
  logic         wr_operand;
  logic         wr_flags;
  logic         wr_status;
  logic         wr_io;
  logic [7:0]   res;
  logic         c_new;

  assign op      = bsfeu_op_t'(cmd_op_reg);
  assign exec    = (state_reg == ST_EXEC);
  assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;

  // byte lanes without strobe keep their zero, registers use low lanes
  assign wr_data = w_data_reg & {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                                 {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign wr_cmd     = wr_fire && is_ctl(aw_addr_reg)
                      && reg_sel(aw_addr_reg) == SEL_CMD;
  assign wr_operand = wr_fire && is_ctl(aw_addr_reg)
                      && reg_sel(aw_addr_reg) == SEL_OPERAND
                      && w_strb_reg[0];
  assign wr_flags   = wr_fire && is_ctl(aw_addr_reg)
                      && reg_sel(aw_addr_reg) == SEL_FLAGS
                      && w_strb_reg[0];
  assign wr_status  = wr_fire && is_ctl(aw_addr_reg)
                      && reg_sel(aw_addr_reg) == SEL_STATUS;
  assign wr_io      = wr_fire && is_io(aw_addr_reg) && w_strb_reg[0];

  // ****************************************************************
  // datapath: result and flags of the current instruction
  // ****************************************************************
  always_comb begin
    res          = operand_reg;
    c_new        = flags_reg[FLAG_C];
    operand_next = operand_reg;
    flags_next   = flags_reg;
    unique case (op)
      OP_SHIFT_LEFT_LOGICAL: begin
        res   = {operand_reg[6:0], 1'b0};                      // RULE3
        c_new = operand_reg[7];
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        res   = {1'b0, operand_reg[7:1]};                      // RULE4
        c_new = operand_reg[0];
      end
      OP_ROTATE_LEFT_CARRY: begin
        res   = {operand_reg[6:0], flags_reg[FLAG_C]};         // RULE5
        c_new = operand_reg[7];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        res   = {flags_reg[FLAG_C], operand_reg[7:1]};         // RULE6
        c_new = operand_reg[0];
      end
      OP_SHIFT_RIGHT_ARITHMETIC: begin
        res   = {operand_reg[7], operand_reg[7:1]};            // RULE7
        c_new = operand_reg[0];
      end
      OP_NIBBLE_SWAP: begin
        res = {operand_reg[3:0], operand_reg[7:4]};            // RULE8
      end
      OP_LOAD_TRANSFER_FLAG_TO_REG_BIT: begin
        res = flags_reg[FLAG_T]                                // RULE10
              ? (operand_reg | bit_mask(cmd_bit_reg))
              : (operand_reg & ~bit_mask(cmd_bit_reg));
      end
      OP_NOP, OP_SET_IO_BIT, OP_CLEAR_IO_BIT,
      OP_STORE_REG_BIT_TO_TRANSFER_FLAG, OP_FLAG_SET, OP_FLAG_CLEAR,
      OP_SLEEP, OP_WATCHDOG_RESTART_OP, OP_DEBUG_BREAK: begin
      end
    endcase
    unique case (op)
      OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
      OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
      OP_SHIFT_RIGHT_ARITHMETIC: begin
        // only Z C N V move; S and H stay as they were
        operand_next       = res;                       // RULE3 RULE4
        flags_next[FLAG_C] = c_new;                     // RULE5 RULE6
        flags_next[FLAG_Z] = (res == 8'h00);            // RULE7
        flags_next[FLAG_N] = res[7];
        flags_next[FLAG_V] = res[7] ^ c_new;
      end
      OP_NIBBLE_SWAP, OP_LOAD_TRANSFER_FLAG_TO_REG_BIT: begin
        operand_next = res;                                    // RULE8
      end
      OP_STORE_REG_BIT_TO_TRANSFER_FLAG: begin
        flags_next[FLAG_T] = |(operand_reg & bit_mask(cmd_bit_reg)); // RULE9
      end
      OP_FLAG_SET: begin
        // bit index picks C Z N V S H T I
        flags_next = flags_reg | bit_mask(cmd_bit_reg); // RULE11 RULE12
      end
      OP_FLAG_CLEAR: begin
        flags_next = flags_reg & ~bit_mask(cmd_bit_reg); // RULE13 RULE17
      end
      OP_NOP, OP_SET_IO_BIT, OP_CLEAR_IO_BIT, OP_SLEEP,
      OP_WATCHDOG_RESTART_OP, OP_DEBUG_BREAK: begin
      end
    endcase
  end

  // ****************************************************************
  // sequencer: one execute cycle, io bit ops add a write-back cycle
  // ****************************************************************
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (wr_cmd) begin
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (op == OP_SET_IO_BIT || op == OP_CLEAR_IO_BIT) begin
            state_reg <= ST_IO_WR;                       // RULE1 RULE2
          end else begin
            state_reg <= ST_IDLE;                        // RULE14 RULE15
          end
        end
        ST_IO_WR: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // a command written while busy is dropped; software polls busy first
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      cmd_op_reg  <= 4'h0;
      cmd_bit_reg <= 3'h0;
      cmd_io_reg  <= 3'h0;
    end else if (wr_cmd && state_reg == ST_IDLE) begin
      cmd_op_reg  <= wr_data[CMD_OP_LSB +: 4];
      cmd_bit_reg <= wr_data[CMD_BIT_LSB +: 3];
      cmd_io_reg  <= wr_data[CMD_IO_LSB +: 3];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_reg == ST_IDLE) ? wr_cmd
                : !(exec && op != OP_SET_IO_BIT && op != OP_CLEAR_IO_BIT
                    || state_reg == ST_IO_WR);
    end
  end

  // execution wins over a software write in the same cycle
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      operand_reg <= OPERAND_RST;
    end else if (exec) begin
      operand_reg <= operand_next;
    end else if (wr_operand) begin
      operand_reg <= wr_data[7:0];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      flags_reg <= FLAGS_RST;
    end else if (exec) begin
      flags_reg <= flags_next;                           // RULE18 RULE16
    end else if (wr_flags) begin
      flags_reg <= wr_data[7:0];
    end
  end

  // ****************************************************************
  // io space: read in execute, modified bit written back next cycle
  // ****************************************************************
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      io_tmp_reg <= 8'h00;
    end else if (exec) begin
      io_tmp_reg <= io_mem_reg[cmd_io_reg];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < IO_COUNT; i++) begin
        io_mem_reg[i] <= 8'h00;
      end
    end else if (state_reg == ST_IO_WR) begin
      io_mem_reg[cmd_io_reg] <= (op == OP_SET_IO_BIT)
        ? (io_tmp_reg | bit_mask(cmd_bit_reg))                 // RULE1
        : (io_tmp_reg & ~bit_mask(cmd_bit_reg));               // RULE2
    end else if (wr_io) begin
      io_mem_reg[aw_addr_reg[2 +: IO_AW]] <= wr_data[7:0];
    end
  end

  // ****************************************************************
  // control pulses and sticky status; hardware set beats clear
  // ****************************************************************
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      wdt_reg   <= 1'b0;
      sleep_reg <= 1'b0;
      break_reg <= 1'b0;
    end else begin
      wdt_reg   <= exec && op == OP_WATCHDOG_RESTART_OP;       // RULE15
      sleep_reg <= exec && op == OP_SLEEP;                     // RULE14
      break_reg <= exec && op == OP_DEBUG_BREAK;               // RULE16
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      break_seen_reg <= 1'b0;
      sleep_seen_reg <= 1'b0;
    end else begin
      break_seen_reg <= break_reg || break_seen_reg
                        && !(wr_status && wr_data[STAT_BREAK]);
      sleep_seen_reg <= sleep_reg || sleep_seen_reg
                        && !(wr_status && wr_data[STAT_SLEEP]);
    end
  end

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
    end else if (bvalid_reg && S_AXI_BREADY) begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
    end else begin
      if (!aw_got_reg && !bvalid_reg) begin
        awready_reg <= !(S_AXI_AWVALID && awready_reg);
      end
      if (!w_got_reg && !bvalid_reg) begin
        wready_reg <= !(S_AXI_WVALID && wready_reg);
      end
      if (S_AXI_AWVALID && awready_reg) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wready_reg) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (is_ctl(aw_addr_reg) || is_io(aw_addr_reg))
                    ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= RESP_OKAY;
    end else if (rvalid_reg) begin
      rvalid_reg  <= !S_AXI_RREADY;
      arready_reg <= S_AXI_RREADY;
    end else if (S_AXI_ARVALID && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h0;
      if (is_io(S_AXI_ARADDR)) begin
        rdata_reg[7:0] <= io_mem_reg[S_AXI_ARADDR[2 +: IO_AW]];
      end else if (is_ctl(S_AXI_ARADDR)) begin
        unique case (reg_sel(S_AXI_ARADDR))
          SEL_CMD:     rdata_reg[10:0] <= {cmd_io_reg, 1'b0,
                                           cmd_bit_reg, cmd_op_reg};
          SEL_OPERAND: rdata_reg[7:0]  <= operand_reg;
          SEL_FLAGS:   rdata_reg[7:0]  <= flags_reg;
          SEL_STATUS:  rdata_reg[2:0]  <= {sleep_seen_reg,
                                           break_seen_reg, busy_reg};
        endcase
      end else begin
        rresp_reg <= RESP_SLVERR;
      end
    end else begin
      arready_reg <= 1'b1;
    end
  end

  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY  = wready_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign WDT_RESTART   = wdt_reg;
  assign SLEEP_REQ     = sleep_reg;
  assign DEBUG_BREAK   = break_reg;
  assign BUSY          = busy_reg;

endmodule // bsfeu_top

//--- tb/bsfeu_props.sv
// checker: execution timing and control pulses at the unit's ports
`timescale 1ns/1ps
module bsfeu_chk (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic S_AXI_BVALID,
  input wire logic WDT_RESTART,
  input wire logic SLEEP_REQ,
  input wire logic DEBUG_BREAK,
  input wire logic BUSY
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // ****************************************************************
  // execution cadence
  // ****************************************************************
  property p_busy_start;
    $rose(BUSY) |-> $rose(S_AXI_BVALID);
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy rose without a write answer");
  property p_busy_len;
    $rose(BUSY) |-> ##[1:2] !BUSY;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy held beyond two cycles");
  property p_wdt_exec;
    $rose(WDT_RESTART) |-> $fell(BUSY);
  endproperty
  a_wdt_exec: assert property (p_wdt_exec)
    else $error("watchdog pulse outside execute edge");
  property p_wdt_one;
    WDT_RESTART |=> !WDT_RESTART;
  endproperty
  a_wdt_one: assert property (p_wdt_one)
    else $error("watchdog pulse longer than one cycle");
  property p_slp_exec;
    $rose(SLEEP_REQ) |-> $fell(BUSY);
  endproperty
  a_slp_exec: assert property (p_slp_exec)
    else $error("sleep pulse outside execute edge");
  property p_slp_one;
    SLEEP_REQ |=> !SLEEP_REQ;
  endproperty
  a_slp_one: assert property (p_slp_one)
    else $error("sleep pulse longer than one cycle");
  property p_brk_exec;
    $rose(DEBUG_BREAK) |-> $fell(BUSY);
  endproperty
  a_brk_exec: assert property (p_brk_exec)
    else $error("break pulse outside execute edge");
  property p_brk_one;
    DEBUG_BREAK |=> !DEBUG_BREAK;
  endproperty
  a_brk_one: assert property (p_brk_one)
    else $error("break pulse longer than one cycle");
  property p_pulse_excl;
    $onehot0({WDT_RESTART, SLEEP_REQ, DEBUG_BREAK});
  endproperty
  a_pulse_excl: assert property (p_pulse_excl)
    else $error("two control pulses at once");
endmodule // bsfeu_chk

bind bsfeu_top bsfeu_chk chk_u (.CLK_SYS, .RESET, .S_AXI_BVALID,
  .WDT_RESTART, .SLEEP_REQ, .DEBUG_BREAK, .BUSY);

//--- tb/tb.sv
// testbench: register-level tests of the bit, shift and flag unit
`timescale 1ns/1ps
module tb
  import bsfeu_pkg::*;
;
  logic        CLK_SYS, RESET, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
  logic        S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, BUSY;
  logic        WDT_RESTART, SLEEP_REQ, DEBUG_BREAK;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, a;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rv, pl;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic [7:0]  dtab [4] = '{8'h81, 8'h40, 8'h01, 8'h00};
  int          fail_count, compares, cyc;

  bsfeu_top dut_u (.CLK_SYS, .RESET, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .WDT_RESTART,
    .SLEEP_REQ, .DEBUG_BREAK, .BUSY);

  // ****************************************************************
  // bus tasks and reference model
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // bready and rready stay high so no answer is ever missed
  task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    S_AXI_AWADDR <= ad;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    while (!(aw && w)) begin
      @(posedge CLK_SYS);
      if (!aw && S_AXI_AWREADY === 1'b1) begin
        aw = 1'b1;
        S_AXI_AWVALID <= 1'b0;
      end
      if (!w && S_AXI_WREADY === 1'b1) begin
        w = 1'b1;
        S_AXI_WVALID <= 1'b0;
      end
    end
    do @(posedge CLK_SYS); while (S_AXI_BVALID !== 1'b1);
    r = S_AXI_BRESP;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] d,
                    output logic [1:0] r);
    S_AXI_ARADDR <= ad;
    S_AXI_ARVALID <= 1'b1;
    do @(posedge CLK_SYS); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLK_SYS); while (S_AXI_RVALID !== 1'b1);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
  endtask

  // counts busy cycles from the answer edge; pulses seen one edge later
  task automatic exec(input logic [3:0] op, input logic [2:0] b,
                      input logic [2:0] io);
    wr(ADDR_CMD, {21'h0, io, 1'b0, b, op}, rsp);
    cyc = 0;
    pl = 32'hF;
    while (BUSY === 1'b1 && cyc < 8) begin
      cyc++;
      @(posedge CLK_SYS);
      if (cyc == 1)
        pl = {29'h0, WDT_RESTART, SLEEP_REQ, DEBUG_BREAK};
    end
  endtask

  function automatic logic [15:0] model(logic [3:0] op, logic [2:0] b,
                                        logic [7:0] d, logic [7:0] f);
    logic [7:0] r, g;
    logic       c;
    r = d;
    g = f;
    c = f[FLAG_C];
    case (op)
      4'h3: begin r = {d[6:0], 1'b0}; c = d[7]; end
      4'h4: begin r = {1'b0, d[7:1]}; c = d[0]; end
      4'h5: begin r = {d[6:0], f[FLAG_C]}; c = d[7]; end
      4'h6: begin r = {f[FLAG_C], d[7:1]}; c = d[0]; end
      4'h7: begin r = {d[7], d[7:1]}; c = d[0]; end
      4'h8: r = {d[3:0], d[7:4]};
      4'h9: g[FLAG_T] = d[b];
      4'hA: r[b] = f[FLAG_T];
      4'hB: g[b] = 1'b1;
      4'hC: g[b] = 1'b0;
      default: ;
    endcase
    if (op >= 4'h3 && op <= 4'h7) begin
      g[FLAG_C] = c;
      g[FLAG_Z] = (r == 8'h00);
      g[FLAG_N] = r[7];
      g[FLAG_V] = r[7] ^ c;
    end
    return {r, g};
  endfunction

  // flag ops start from the opposite value so every force shows
  task automatic check_op(input logic [3:0] op, input logic [2:0] k);
    logic [7:0]  d, f;
    logic [15:0] e;
    d = dtab[k[1:0]];
    f = (op == 4'hB) ? 8'h00 : (op == 4'hC) ? 8'hFF :
        (k[2] ? 8'hCE : 8'h31);
    e = model(op, k, d, f);
    wr(ADDR_OPERAND, {24'h0, d}, rsp);
    wr(ADDR_FLAGS, {24'h0, f}, rsp);
    exec(op, k, 3'h0);
    rd(ADDR_OPERAND, rv, rsp);
    chk(rv, {24'h0, e[15:8]});
    rd(ADDR_FLAGS, rv, rsp);
    chk(rv, {24'h0, e[7:0]});
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    chk(cyc, 32'h1);
    chk(pl, 32'h0);
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // clock, watchdog and test sequence
  // ****************************************************************
  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end

  initial begin
    repeat (40000) @(posedge CLK_SYS);
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    RESET = 1'b1;
    S_AXI_AWVALID = 1'b0;
    S_AXI_WVALID = 1'b0;
    S_AXI_ARVALID = 1'b0;
    S_AXI_BREADY = 1'b1;
    S_AXI_RREADY = 1'b1;
    S_AXI_AWADDR = 8'h00;
    S_AXI_ARADDR = 8'h00;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'hF;
    repeat (4) @(posedge CLK_SYS);
    RESET <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    rd(8'h10, rv, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(8'h10, 32'hFF, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    $display("test unmapped done");
    for (int o = 3; o <= 8; o++)
      for (int k = 0; k < 8; k++)
        check_op(o[3:0], k[2:0]);
    for (int o = 9; o <= 10; o++)
      for (int k = 0; k < 8; k++)
        check_op(o[3:0], k[2:0]);
    for (int o = 11; o <= 12; o++)
      for (int k = 0; k < 8; k++)
        check_op(o[3:0], k[2:0]);
    $display("test shifts and flags done");
    wr(ADDR_FLAGS, 32'h5A, rsp);
    for (int i = 0; i < 8; i++) begin
      a = ADDR_IO_BASE + 8'(4 * i);
      wr(a, 32'h0, rsp);
      exec(4'h1, 3'(7 - i), i[2:0]);
      chk(cyc, 32'h2);
      rd(a, rv, rsp);
      chk(rv, 32'h1 << (7 - i));
      wr(a, 32'hFF, rsp);
      exec(4'h2, 3'(7 - i), i[2:0]);
      chk(cyc, 32'h2);
      rd(a, rv, rsp);
      chk(rv, 32'hFF ^ (32'h1 << (7 - i)));
    end
    rd(ADDR_FLAGS, rv, rsp);
    chk(rv, 32'h5A);
    $display("test io bits done");
    wr(ADDR_FLAGS, 32'hA5, rsp);
    exec(4'hE, 3'h0, 3'h0);
    chk(pl, 32'h4);
    chk(cyc, 32'h1);
    exec(4'hD, 3'h0, 3'h0);
    chk(pl, 32'h2);
    chk(cyc, 32'h1);
    exec(4'hF, 3'h0, 3'h0);
    chk(pl, 32'h1);
    rd(ADDR_FLAGS, rv, rsp);
    chk(rv, 32'hA5);
    // sleep and break leave sticky marks until software clears them
    rd(ADDR_STATUS, rv, rsp);
    chk(rv, 32'h6);
    wr(ADDR_STATUS, 32'h6, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rd(ADDR_STATUS, rv, rsp);
    chk(rv, 32'h0);
    $display("test control opcodes done");
    complete_run();
  end
endmodule // tb
